//--- hdl/srg_pkg.sv
// Package with constants and types for the supervisor reset generator.
package srg_pkg;

    // Output variant chosen at build time
    typedef enum logic [1:0] {
        SRG_OUT_LOW_PP  = 2'b00,
        SRG_OUT_HIGH_PP = 2'b01,
        SRG_OUT_LOW_OD  = 2'b10
    } srg_variant_t;

    // Reset delay option chosen at build time
    typedef enum logic [1:0] {
        SRG_DLY_SHORT = 2'b00,
        SRG_DLY_MID   = 2'b01,
        SRG_DLY_LONG  = 2'b10
    } srg_delay_t;

    localparam int unsigned SRG_CLK_HZ = 100_000_000;
    localparam int unsigned SRG_CLK_NS = 10;

    // Minimum hold times in microseconds
    localparam int unsigned SRG_DLY_SHORT_US = 1090;
    localparam int unsigned SRG_DLY_MID_US = 17500;
    localparam int unsigned SRG_DLY_LONG_US = 140000;
    // Least times round up to whole cycles
    localparam int unsigned SRG_DLY_SHORT_CYC =
        (SRG_DLY_SHORT_US * 1000 + SRG_CLK_NS - 1) / SRG_CLK_NS;
    localparam int unsigned SRG_DLY_MID_CYC =
        (SRG_DLY_MID_US * 1000 + SRG_CLK_NS - 1) / SRG_CLK_NS;
    localparam int unsigned SRG_DLY_LONG_CYC =
        (SRG_DLY_LONG_US * 1000 + SRG_CLK_NS - 1) / SRG_CLK_NS;

    // Longest supply-drop to output latency
    localparam int unsigned SRG_TRIP_MAX_US = 50;
    localparam int unsigned SRG_TRIP_MAX_CYC =
        SRG_TRIP_MAX_US * 1000 / SRG_CLK_NS;

    // Minimum accepted manual low time, a plain default
    localparam int unsigned SRG_MR_MIN_US = 20;
    localparam int unsigned SRG_MR_MIN_CYC =
        (SRG_MR_MIN_US * 1000 + SRG_CLK_NS - 1) / SRG_CLK_NS;

    localparam int unsigned SRG_CNT_W = 24;
    localparam logic [SRG_CNT_W-1:0] SRG_CNT_ZERO = 24'h000000;
    localparam logic [SRG_CNT_W-1:0] SRG_CNT_ONE = 24'h000001;

    // Reset-cause vector
    typedef struct packed {
        logic power_up;
        logic under_trip;
        logic manual;
    } srg_cause_t;

    localparam srg_cause_t SRG_CAUSE_RST = 3'b100;

endpackage : srg_pkg

//--- hdl/srg_reset_gen.sv
// Supervisor reset generator: causes, filter, delay timer, output drive.

// Summary of operation
// [RL1] Reset asserted during power-up, supply under threshold, or manual low.
// [RL2] Low push-pull variant: low while under trip, then the selected delay hold (140 ms by default).
// [RL3] High push-pull variant: high while under trip, high for delay, low.
// [RL4] Open-drain variant pulls low while active, releases after delay.
// [RL5] Delay options hold at least 1.09 ms, 17.5 ms or 140 ms.
// [RL6] Manual input filtered; only a sustained low counts as a request.
// [RL7] Manual input active low, pulled up; high leaves other causes in charge.
// [RL8] Output polarity and drive style are build-time variants.
// [RL9] Delay timer starts once all causes clear; output clears at expiry.
// [RL10] Accepted supply drop asserts reset within 50 microseconds.
// [RL11] Delay and filter counted in clock cycles; restart on any new cause.
module srg_reset_gen
    import srg_pkg::*;
#(
    parameter srg_variant_t VARIANT = SRG_OUT_LOW_PP,
    parameter srg_delay_t DELAY_SEL = SRG_DLY_LONG,
    parameter int unsigned DLY_SHORT_CYC = SRG_DLY_SHORT_CYC,
    parameter int unsigned DLY_MID_CYC = SRG_DLY_MID_CYC,
    parameter int unsigned DLY_LONG_CYC = SRG_DLY_LONG_CYC,
    parameter int unsigned MR_MIN_CYC = SRG_MR_MIN_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic supply_below_trip_i,
    input wire logic manual_reset_request_n_i,
    output logic sys_reset_out_o,
    output logic sys_reset_oe_o,
    output logic reset_active_o
);

    // Selected delay, reduced to the counter width
    localparam int unsigned DLY_CYC =
        (DELAY_SEL == SRG_DLY_SHORT) ? DLY_SHORT_CYC :
        (DELAY_SEL == SRG_DLY_MID) ? DLY_MID_CYC : DLY_LONG_CYC; // see [RL5]
    localparam logic [SRG_CNT_W-1:0] DLY_LAST =
        SRG_CNT_W'(DLY_CYC - 1);
    localparam logic [SRG_CNT_W-1:0] MR_LAST =
        SRG_CNT_W'(MR_MIN_CYC - 1);

    // One flop per cause, each with its own process, packed below
    logic power_up_q;
    logic under_trip_q;
    logic manual_q;
    srg_cause_t cause_q;
    logic [SRG_CNT_W-1:0] mr_cnt_q;
    logic [SRG_CNT_W-1:0] dly_cnt_q;
    logic active_q;
    logic any_cause;

    // Power-up cause holds until the first enabled cycle after reset
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            power_up_q <= 1'b1;
        end else if (clk_en_i) begin
            power_up_q <= 1'b0;
        end
    end

    // Supply comparator registered once: one cycle here, two cycles to the output pins
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            under_trip_q <= 1'b1;
        end else if (clk_en_i) begin
            under_trip_q <= supply_below_trip_i; // see [RL10]
        end
    end

    // Manual low must last MR_MIN_CYC cycles; any high restarts the count
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            mr_cnt_q <= SRG_CNT_ZERO;
            manual_q <= 1'b0;
        end else if (clk_en_i) begin
            if (manual_reset_request_n_i) begin
                mr_cnt_q <= SRG_CNT_ZERO; // see [RL7]
                manual_q <= 1'b0;
            end else if (mr_cnt_q >= MR_LAST) begin
                manual_q <= 1'b1; // see [RL6]
            end else begin
                mr_cnt_q <= mr_cnt_q + SRG_CNT_ONE; // see [RL11]
            end
        end
    end

    assign cause_q = {power_up_q, under_trip_q, manual_q};

    assign any_cause = cause_q.power_up | cause_q.under_trip |
                       cause_q.manual;

    // Delay timer: cleared while any cause stands, runs once all clear
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            dly_cnt_q <= SRG_CNT_ZERO;
            active_q <= 1'b1;
        end else if (clk_en_i) begin
            if (any_cause) begin
                dly_cnt_q <= SRG_CNT_ZERO; // see [RL11]
                active_q <= 1'b1; // see [RL1]
            end else if (active_q) begin
                if (dly_cnt_q >= DLY_LAST) begin
                    active_q <= 1'b0; // see [RL9]
                end else begin
                    dly_cnt_q <= dly_cnt_q + SRG_CNT_ONE; // see [RL9]
                end
            end
        end
    end

    // Output pin stage; registered so the pin never glitches
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            sys_reset_out_o <= (VARIANT == SRG_OUT_HIGH_PP);
            sys_reset_oe_o <= 1'b1;
            reset_active_o <= 1'b1;
        end else if (clk_en_i) begin
            reset_active_o <= any_cause | active_q;
            unique case (VARIANT) // see [RL8]
                SRG_OUT_LOW_PP: begin
                    sys_reset_out_o <= ~(any_cause | active_q); // see [RL2]
                    sys_reset_oe_o <= 1'b1;
                end
                SRG_OUT_HIGH_PP: begin
                    sys_reset_out_o <= any_cause | active_q; // see [RL3]
                    sys_reset_oe_o <= 1'b1;
                end
                SRG_OUT_LOW_OD: begin
                    sys_reset_out_o <= 1'b0;
                    sys_reset_oe_o <= any_cause | active_q; // see [RL4]
                end
                default: begin
                    sys_reset_out_o <= 1'b0;
                    sys_reset_oe_o <= 1'b1;
                end
            endcase
        end
    end

endmodule // srg_reset_gen

//--- testbench/srg_reset_gen_assertions.sv
// Port checker for the supervisor reset generator.
module srg_reset_gen_assertions
    import srg_pkg::*;
#(parameter srg_variant_t VARIANT = SRG_OUT_LOW_PP, parameter int DLY = 20) (
    input logic mclk_i,
    input logic reset_i,
    input logic clk_en_i,
    input logic supply_below_trip_i,
    input logic manual_reset_request_n_i,
    input logic sys_reset_out_o,
    input logic sys_reset_oe_o,
    input logic reset_active_o
);
    wire en = clk_en_i, sb = supply_below_trip_i, act = reset_active_o;
    wire mr = manual_reset_request_n_i;
    int calm_q;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // Enabled cycles since the supply was last under threshold
    always_ff @(posedge mclk_i or posedge reset_i)
        if (reset_i)
            calm_q <= 0;
        else if (en)
            calm_q <= sb ? 0 : calm_q + 1;
    // Fixed counts fit a four- or five-cycle filter only
    sequence s_short; mr ##1 !mr [*3] ##1 mr; endsequence
    sequence s_long; (en && !mr) [*6]; endsequence
    property p_trip; en && sb ##1 en [*2] |=> act; endproperty
    property p_stay; (en && sb) [*4] |-> act; endproperty
    property p_short; (en && !sb && !act) throughout s_short |=> !act;
    endproperty
    property p_long; s_long |=> act; endproperty
    property p_hold; $fell(act) |-> calm_q >= DLY; endproperty
    property p_freeze; !en |=> $stable(act) && $stable(sys_reset_oe_o);
    endproperty
    property p_od; VARIANT == SRG_OUT_LOW_OD |->
        sys_reset_oe_o == act && !sys_reset_out_o; endproperty
    a_trip: assert property (p_trip) else $error("late trip");
    a_stay: assert property (p_stay) else $error("no trip");
    a_short: assert property (p_short) else $error("glitch");
    a_long: assert property (p_long) else $error("push lost");
    a_hold: assert property (p_hold) else $error("short hold");
    a_freeze: assert property (p_freeze) else $error("moved");
    a_od: assert property (p_od) else $error("bad drive");
endmodule // srg_reset_gen_assertions
bind srg_reset_gen srg_reset_gen_assertions #(.VARIANT(VARIANT),
    .DLY(DLY_CYC)) srg_reset_gen_assertions_inst (.*);

//--- testbench/srg_mcu_model.sv
// Far side: a controller held in reset by the output pin.
module srg_mcu_model
    import srg_pkg::*;
#(parameter srg_variant_t VARIANT = SRG_OUT_LOW_PP) (
    input logic pin_out_i,
    input logic pin_oe_i,
    output logic held_o
);
    // Released pin floats up to the board pull-up
    assign held_o = (!pin_oe_i | pin_out_i) ^
        (VARIANT != SRG_OUT_HIGH_PP);
endmodule // srg_mcu_model

//--- testbench/srg_reset_gen_tb_top.sv
// Bench for the reset generator, all three output builds side by side.
module srg_reset_gen_tb_top;
    import srg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D = 20;
    logic mclk_i = 0, reset_i = 1, en = 1, sb = 0, mr = 1;
    logic [2:0] out, oe, act, held;
    int n_mismatch = 0, n_checks = 0, n;
    always #5 mclk_i = ~mclk_i;
    // One copy per output build, all fed the same causes
    for (genvar v = 0; v < 3; v++) begin : g_var
        localparam srg_variant_t VAR = srg_variant_t'(v);
        srg_reset_gen #(.VARIANT(VAR), .DELAY_SEL(SRG_DLY_SHORT),
            .DLY_SHORT_CYC(D), .MR_MIN_CYC(4)) srg_reset_gen_inst (
            .mclk_i, .reset_i, .clk_en_i(en), .supply_below_trip_i(sb),
            .manual_reset_request_n_i(mr), .sys_reset_out_o(out[v]),
            .sys_reset_oe_o(oe[v]), .reset_active_o(act[v]));
        srg_mcu_model #(.VARIANT(VAR)) srg_mcu_model_inst (
            .pin_out_i(out[v]), .pin_oe_i(oe[v]), .held_o(held[v]));
    end
    task chk(input logic [2:0] seen, input logic [2:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t reset state", $time);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Sample just past the edge so the design's updates have landed
    task look(input logic exp);
        #1 chk(held, {3{exp}});
        chk(act, {3{exp}});
        @(posedge mclk_i);
    endtask
    task step(input logic s, input logic m, input int k);
        sb <= s;
        mr <= m;
        repeat (k) @(posedge mclk_i);
    endtask
    task free(input int lo);
        #1 n = 0;
        while (held !== 3'b000 && n < 300) @(posedge mclk_i) #1 n++;
        chk({2'b00, n >= lo && n <= D + 6}, 3'b001);
        chk(act, 3'b000);
        if (n >= 300)
            print_verdict;
        @(posedge mclk_i);
    endtask
    task pulse;
        step(1, 1, 1);
        step(0, 1, 2);
        look(1);
    endtask
    task t_power;
        look(1);
        free(D);
    endtask
    // Freeze outlasts the delay, so only a held timer keeps reset on
    task t_trip;
        pulse;
        en <= 0;
        repeat (30) @(posedge mclk_i);
        en <= 1;
        look(1);
        pulse;
        free(D - 2);
    endtask
    task t_manual;
        step(0, 0, 3);
        step(0, 1, 3);
        look(0);
        step(0, 0, 6);
        look(1);
        step(0, 1, 0);
        free(D);
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        reset_i <= 0;
        t_power;
        t_trip;
        t_manual;
        print_verdict;
    end
endmodule // srg_reset_gen_tb_top
